/* File: pm_cap_pkg.sv */
package pm_cap_pkg;

  // Configuration space layout, byte offsets of aligned dwords
  localparam logic [7:0] STATUS_DW_OFF   = 8'h04;
  localparam logic [7:0] CAP_PTR_DW_OFF  = 8'h34;
  localparam logic [7:0] PM_CAP_DW_OFF   = 8'h40;
  localparam logic [7:0] PM_CSR_DW_OFF   = 8'h44;

  // Field positions inside their dwords
  localparam int CAP_LIST_BIT    = 20;
  localparam int CAP_PTR_LSB     = 0;
  localparam int CAPABILITY_IDENTIFIER_LSB      = 0;
  localparam int NEXT_PTR_LSB    = 8;
  localparam int PM_CAPS_LSB     = 16;
  localparam int PSTATE_LSB      = 0;
  localparam int PME_EN_BIT      = 8;
  localparam int PME_STS_BIT     = 15;
  localparam int BRIDGE_EXT_LSB  = 16;
  localparam int POWER_DATA_LSB  = 24;

  // Power state encodings
  localparam logic [1:0] PSTATE_D0    = 2'h0;
  localparam logic [1:0] PSTATE_D3HOT = 2'h3;

  // Reset values
  localparam logic [1:0] PSTATE_RST     = 2'h0;
  localparam logic       PME_EN_RST     = 1'h0;
  localparam logic       PME_STS_RST    = 1'h0;
  localparam logic [7:0] POWER_DATA_RST = 8'h00;

  // Length of the internal warm reset pulse in core_clk cycles
  localparam int WARM_RST_CYCLES = 4;

  typedef enum logic [0:0] {
    run_st,
    warm_rst_st
  } warm_state_type;

endpackage

/* File: pm_cap_regs.sv */
`timescale 1ns/100ps
// Functional notes
// - Status register bit 4 reads one, advertising a capability list.
// - Capability pointer at offset 34h points to the power register file.
// - Register file holds 8-bit capability identifier and 8-bit next pointer.
// - Capability list structure bits are read-only constants.
// - 16-bit read-only power capabilities register.
// - 16-bit control/status register; bits 1:0 are a writable power state.
// - 8-bit read-only bridge extension; nonzero only for bridges.
// - 8-bit read-only power data register reads all zeros.
// - D0 means fully configured and operational.
// - D3hot is restorable without boot; survives stopped clocks.
// - Configuration cycles are accepted and answered in D3hot.
// - In D3hot ignore I/O and memory cycles, hold interrupts low.
// - In D3hot start no transaction except split completions.
// - Writing D0 from D3hot applies an internal warm reset.
// - Optional wake request pin asserted on external stimulus.
module pm_cap_regs
  import pm_cap_pkg::*;
#(
  parameter logic [7:0]  CAPABILITY_IDENTIFIER         = 8'h01,
  parameter logic [7:0]  NEXT_CAP_PTR   = 8'h00,
  parameter logic [15:0] PM_CAPS        = 16'h0002,
  parameter logic        IS_BRIDGE      = 1'b0,
  parameter logic [7:0]  BRIDGE_EXT_VAL = 8'h00,
  parameter logic        WAKE_EN        = 1'b0,
  parameter int          WARM_CYCLES    = WARM_RST_CYCLES
)(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        cfg_req,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic [31:0]      cfg_rdata,
  input  wire logic        fn_int_req,
  input  wire logic        fn_init_req,
  input  wire logic        fn_init_split_cpl,
  input  wire logic        wake_event,
  output logic [1:0]       power_state,
  output logic             space_enable,
  output logic             int_out,
  output logic             init_grant,
  output logic             func_rst,
  output logic             pme_out,
  output logic             pme_oe
);

  // Elaboration checks
  if (WARM_CYCLES < 1) begin : g_chk_warm
    $error("WARM_CYCLES must be at least one");
  end
  if (!IS_BRIDGE && (BRIDGE_EXT_VAL != 8'h00)) begin : g_chk_bse
    $error("BRIDGE_EXT_VAL must be zero for a non-bridge");
  end
  if (IS_BRIDGE && (BRIDGE_EXT_VAL == 8'h00)) begin : g_chk_bse_nz
    $error("BRIDGE_EXT_VAL must be nonzero for a bridge");
  end
  // Longer warm resets gain nothing and need a wider counter
  if (WARM_CYCLES > 255) begin : g_chk_warm_max
    $error("WARM_CYCLES must not exceed 255");
  end
  // The read assembly below assumes this field layout
  if ((CAP_LIST_BIT < 16) || (CAP_LIST_BIT > 31)) begin : g_chk_list_bit
    $error("CAP_LIST_BIT must lie in the upper half of the status dword");
  end
  if (CAP_PTR_LSB + 8 > 32) begin : g_chk_ptr_lsb
    $error("CAP_PTR_LSB leaves no room for the pointer");
  end
  if (NEXT_PTR_LSB != CAPABILITY_IDENTIFIER_LSB + 8) begin : g_chk_next_lsb
    $error("NEXT_PTR_LSB must follow the identifier");
  end
  if (PM_CAPS_LSB != NEXT_PTR_LSB + 8) begin : g_chk_caps_lsb
    $error("PM_CAPS_LSB must follow the next pointer");
  end
  if (PSTATE_LSB + 2 > PME_EN_BIT) begin : g_chk_ps_lsb
    $error("Power state field overlaps the wake enable");
  end
  if (PME_STS_BIT > 15) begin : g_chk_sts_bit
    $error("PME_STS_BIT must lie in the control/status word");
  end
  if (BRIDGE_EXT_LSB != 16) begin : g_chk_bse_lsb
    $error("BRIDGE_EXT_LSB must follow the control/status word");
  end
  if (POWER_DATA_LSB != BRIDGE_EXT_LSB + 8) begin : g_chk_data_lsb
    $error("POWER_DATA_LSB must follow the bridge extension");
  end
  if (PM_CAP_DW_OFF[1:0] != 2'b00) begin : g_chk_cap_align
    $error("PM_CAP_DW_OFF must be dword aligned");
  end
  if (PM_CSR_DW_OFF != PM_CAP_DW_OFF + 8'h04) begin : g_chk_csr_off
    $error("PM_CSR_DW_OFF must follow the capability dword");
  end

  localparam int CNT_W = $clog2(WARM_CYCLES + 1);
  localparam logic [CNT_W-1:0] WARM_LOAD = CNT_W'(WARM_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = '0;

  // Reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // State
  logic [1:0]       pstate_q;
  logic [1:0]       pstate_d;
  logic             pme_en_q;
  logic             pme_en_d;
  logic             pme_sts_q;
  logic             pme_sts_d;
  warm_state_type   warm_q;
  warm_state_type   warm_d;
  logic [CNT_W-1:0] warm_cnt_q;
  logic [CNT_W-1:0] warm_cnt_d;
  logic             ack_q;
  logic [31:0]      rdata_q;
  logic             space_en_q;
  logic             int_q;
  logic             grant_q;
  logic             func_rst_q;
  logic             pme_out_q;
  logic             pme_oe_q;

  // Address decode
  wire logic [7:0] dw_addr   = {cfg_addr[7:2], 2'b00};
  wire logic       hit_sts   = (dw_addr == STATUS_DW_OFF);
  wire logic       hit_ptr   = (dw_addr == CAP_PTR_DW_OFF);
  wire logic       hit_cap   = (dw_addr == PM_CAP_DW_OFF);
  wire logic       hit_csr   = (dw_addr == PM_CSR_DW_OFF);
  wire logic       rd_stb    = cfg_req && !cfg_write;
  wire logic       wr_csr    = cfg_req && cfg_write && hit_csr;
  wire logic       wr_lo     = wr_csr && cfg_be[0];
  wire logic       wr_hi     = wr_csr && cfg_be[1];

  // Power state write filtering
  wire logic [1:0] ps_wr     = cfg_wdata[PSTATE_LSB +: 2];
  wire logic       ps_legal  = (ps_wr == PSTATE_D0) ||
                               (ps_wr == PSTATE_D3HOT);
  wire logic       ps_take   = wr_lo && ps_legal;
  wire logic       in_d3hot  = (pstate_q == PSTATE_D3HOT);
  wire logic       to_d0     = ps_take && in_d3hot &&
                               (ps_wr == PSTATE_D0);
  wire logic       nxt_d3hot = (pstate_d == PSTATE_D3HOT);

  // Wake request bookkeeping
  wire logic       sts_clr   = wr_hi && cfg_wdata[PME_STS_BIT];
  wire logic       sts_set   = WAKE_EN && wake_event;
  wire logic       en_wr     = wr_hi && WAKE_EN;

  // Warm reset keeps function logic quiet as well
  wire logic       warm_busy = (warm_d == warm_rst_st);

  always_comb begin
    pstate_d = pstate_q;
    if (ps_take) begin
      pstate_d = ps_wr;
    end
  end

  always_comb begin
    pme_en_d = pme_en_q;
    if (en_wr) begin
      pme_en_d = cfg_wdata[PME_EN_BIT];
    end
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    pme_sts_d = pme_sts_q;
    if (sts_clr) begin
      pme_sts_d = 1'b0;
    end
    if (sts_set) begin
      pme_sts_d = 1'b1;
    end
  end

  // Warm reset sequencer
  always_comb begin
    warm_d     = warm_q;
    warm_cnt_d = warm_cnt_q;
    case (warm_q)
      run_st: begin
        if (to_d0) begin
          warm_d     = warm_rst_st;
          warm_cnt_d = WARM_LOAD;
        end
      end
      warm_rst_st: begin
        if (warm_cnt_q == CNT_ONE) begin
          warm_d     = run_st;
          warm_cnt_d = CNT_ZERO;
        end else begin
          warm_cnt_d = warm_cnt_q - CNT_ONE;
        end
      end
      default: begin
        warm_d     = run_st;
        warm_cnt_d = CNT_ZERO;
      end
    endcase
  end

  // Read data assembly; fields sit at their package positions
  wire logic [15:0] csr_word;
  wire logic [31:0] rd_sts;
  wire logic [31:0] rd_ptr;
  wire logic [31:0] rd_cap;
  wire logic [31:0] rd_csr;

  // Status dword carries only the capability list flag
  for (genvar b = 0; b < 32; b++) begin : g_sts_bit
    assign rd_sts[b] = (b == CAP_LIST_BIT);
  end

  // Unimplemented control/status bits read as zero
  for (genvar b = 0; b < 16; b++) begin : g_csr_bit
    if (b == PME_STS_BIT) begin : g_sts
      assign csr_word[b] = pme_sts_q && WAKE_EN;
    end else if (b == PME_EN_BIT) begin : g_en
      assign csr_word[b] = pme_en_q && WAKE_EN;
    end else if ((b >= PSTATE_LSB) && (b < PSTATE_LSB + 2)) begin : g_ps
      assign csr_word[b] = pstate_q[b - PSTATE_LSB];
    end else begin : g_zero
      assign csr_word[b] = 1'b0;
    end
  end

  assign rd_ptr = 32'(PM_CAP_DW_OFF) << CAP_PTR_LSB;
  assign rd_cap = (32'(CAPABILITY_IDENTIFIER) << CAPABILITY_IDENTIFIER_LSB) |
                  (32'(NEXT_CAP_PTR) << NEXT_PTR_LSB) |
                  (32'(PM_CAPS) << PM_CAPS_LSB);
  assign rd_csr = (32'(POWER_DATA_RST) << POWER_DATA_LSB) |
                  (32'(BRIDGE_EXT_VAL) << BRIDGE_EXT_LSB) |
                  32'(csr_word);
  logic [31:0] rd_mux;

  // Unmapped dwords read as zero and are still acknowledged
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_sts) begin
      rd_mux = rd_sts;
    end
    if (hit_ptr) begin
      rd_mux = rd_ptr;
    end
    if (hit_cap) begin
      rd_mux = rd_cap;
    end
    if (hit_csr) begin
      rd_mux = rd_csr;
    end
  end

  // Config cycles are answered in every power state
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= cfg_req;
      rdata_q <= rd_stb ? rd_mux : 32'h00000000;
    end
  end

  // Power state and wake registers; pstate survives warm reset
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pstate_q  <= PSTATE_RST;
      pme_en_q  <= PME_EN_RST;
      pme_sts_q <= PME_STS_RST;
    end else begin
      pstate_q  <= pstate_d;
      pme_en_q  <= pme_en_d;
      pme_sts_q <= pme_sts_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      warm_q     <= run_st;
      warm_cnt_q <= CNT_ZERO;
    end else begin
      warm_q     <= warm_d;
      warm_cnt_q <= warm_cnt_d;
    end
  end

  // Function-facing controls, registered from next state
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      space_en_q <= 1'b1;
      int_q      <= 1'b0;
      grant_q    <= 1'b0;
      func_rst_q <= 1'b0;
    end else begin
      space_en_q <= !nxt_d3hot;
      int_q      <= fn_int_req && !nxt_d3hot && !warm_busy;
      grant_q    <= fn_init_req && !warm_busy &&
                    (!nxt_d3hot || fn_init_split_cpl);
      func_rst_q <= warm_busy;
    end
  end

  // Open-drain wake pin: only the enable toggles, data stays low
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pme_out_q <= 1'b0;
      pme_oe_q  <= 1'b0;
    end else begin
      pme_out_q <= 1'b0;
      pme_oe_q  <= pme_sts_d && pme_en_d && WAKE_EN;
    end
  end

  assign cfg_ack      = ack_q;
  assign cfg_rdata    = rdata_q;
  assign power_state  = pstate_q;
  assign space_enable = space_en_q;
  assign int_out      = int_q;
  assign init_grant   = grant_q;
  assign func_rst     = func_rst_q;
  assign pme_out      = pme_out_q;
  assign pme_oe       = pme_oe_q;

endmodule

/* File: pm_cap_regs_properties.sv */
`timescale 1ns/100ps
module pm_cap_regs_properties
  import pm_cap_pkg::*;
#(
  parameter int WARM_CYCLES = 4
)(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        cfg_req,
  input wire logic        cfg_write,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic        fn_init_split_cpl,
  input wire logic [1:0]  power_state,
  input wire logic        space_enable,
  input wire logic        int_out,
  input wire logic        init_grant,
  input wire logic        func_rst
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire       rd = cfg_req && !cfg_write;
  wire [5:0] dw = cfg_addr[7:2];
  wire       d3 = power_state == PSTATE_D3HOT;
  logic [7:0] len_q;
  // Run length of the warm reset, so its width is checked without a long repetition
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) len_q <= 8'h00;
    else len_q <= func_rst ? len_q + 8'h01 : 8'h00;
  end
  property p_ack; cfg_req |=> cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_status; rd && dw == 6'h01 |=> cfg_rdata == 32'h0010_0000; endproperty
  a_status: assert property (p_status) else $error("status");
  property p_cap_ptr; rd && dw == 6'h0D |=> cfg_rdata == 32'h0000_0040; endproperty
  a_cap_ptr: assert property (p_cap_ptr) else $error("cap ptr");
  property p_csr_hi; rd && dw == 6'h11 |=> cfg_rdata[31:16] == 16'h0000; endproperty
  a_csr_hi: assert property (p_csr_hi) else $error("csr high");
  property p_d3_gate; d3 |-> !space_enable && !int_out; endproperty
  a_d3_gate: assert property (p_d3_gate) else $error("d3 gate");
  property p_d3_init; d3 && init_grant |-> $past(fn_init_split_cpl); endproperty
  a_d3_init: assert property (p_d3_init) else $error("d3 init");
  property p_warm; !d3 && $past(d3) |-> func_rst; endproperty
  a_warm: assert property (p_warm) else $error("no warm rst");
  property p_warm_len; $fell(func_rst) |-> len_q == WARM_CYCLES; endproperty
  a_warm_len: assert property (p_warm_len) else $error("warm len");
  property p_bad_state;
    cfg_req && cfg_write && dw == 6'h11 && cfg_be[0] && ^cfg_wdata[1:0] |=> $stable(power_state);
  endproperty
  a_bad_state: assert property (p_bad_state) else $error("bad state");
endmodule
bind pm_cap_regs pm_cap_regs_properties #(.WARM_CYCLES(WARM_CYCLES)) i_props (
  .core_clk(core_clk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
  .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
  .cfg_rdata(cfg_rdata), .fn_init_split_cpl(fn_init_split_cpl), .power_state(power_state),
  .space_enable(space_enable), .int_out(int_out), .init_grant(init_grant), .func_rst(func_rst)
);

/* File: pm_cap_host_model.sv */
`timescale 1ns/100ps
module pm_cap_host_model (
  input wire logic        core_clk,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output logic            cfg_req,
  output logic            cfg_write,
  output logic [7:0]      cfg_addr,
  output logic [3:0]      cfg_be,
  output logic [31:0]     cfg_wdata
);
  initial begin
    cfg_req = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  // One-cycle request; address and data are inverted when idle so stale values never look valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge core_clk);
    cfg_req <= 1'b1;
    cfg_write <= wr;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_req <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
    do begin
      @(posedge core_clk);
      n++;
    end while (cfg_ack !== 1'b1 && n < 4);
    q = cfg_rdata;
    ok = cfg_ack === 1'b1;
  endtask
endmodule

/* File: minimal_power_mgmt_capability_tb.sv */
`timescale 1ns/100ps
module minimal_power_mgmt_capability_tb;
  import pm_cap_pkg::*;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cfg_req, cfg_write, cfg_ack, space_enable, int_out, init_grant, func_rst, ok;
  logic        pme_out, pme_oe;
  logic        fn_int_req = 1'b0, fn_init_req = 1'b0, fn_init_split_cpl = 1'b0, wake_event = 1'b0;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, q;
  logic [1:0]  power_state, st;
  int          seed = 28112, n_mismatch = 0, checked = 0, rst_len = 0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) {fn_int_req, fn_init_req, fn_init_split_cpl, wake_event} <= 4'($random(seed));
  always @(posedge core_clk) if (func_rst === 1'b1) rst_len++;
  pm_cap_regs #(.WARM_CYCLES(4)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .fn_int_req(fn_int_req), .fn_init_req(fn_init_req),
    .fn_init_split_cpl(fn_init_split_cpl), .wake_event(wake_event), .power_state(power_state),
    .space_enable(space_enable), .int_out(int_out), .init_grant(init_grant),
    .func_rst(func_rst), .pme_out(pme_out), .pme_oe(pme_oe)
  );
  pm_cap_host_model i_host (
    .core_clk(core_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req),
    .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    i_host.access(wr, a, be, d, q, ok);
    if (!ok) begin
      n_mismatch++;
      summarize();
    end
  endtask
  initial begin
    logic [7:0]  ra [5] = '{8'h04, 8'h34, 8'h40, 8'h44, 8'h08};
    logic [31:0] rx [5] = '{32'h0010_0000, 32'h0000_0040, 32'h0002_0001, 32'h0, 32'h0};
    logic [31:0] d;
    logic [3:0]  be;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    xfer(1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
    foreach (ra[i]) begin
      xfer(1'b0, ra[i], 4'hF, 32'h0);
      check(q, rx[i]);
    end
    $display("done: read-only map");
    xfer(1'b1, 8'h44, 4'h1, 32'h3);
    check({30'h0, space_enable, int_out}, 32'h0);
    for (int v = 1; v < 3; v++) begin
      xfer(1'b1, 8'h44, 4'h1, 32'(v));
      xfer(1'b0, 8'h44, 4'hF, 32'h0);
      check(q, 32'h3);
    end
    xfer(1'b1, 8'h44, 4'h1, 32'h0);
    repeat (8) @(posedge core_clk);
    check({power_state, 30'(rst_len)}, 32'h4);
    $display("done: state changes");
    st = 2'h0;
    repeat (24) begin
      d = $random(seed);
      be = 4'($random(seed));
      xfer(1'b1, 8'h44, be, d);
      if (be[0] && !(^d[1:0])) st = d[1:0];
      xfer(1'b0, 8'h44, 4'hF, 32'h0);
      check(q, {30'h0, st});
    end
    check({30'h0, pme_out, pme_oe}, 32'h0);
    $display("done: random writes");
    summarize();
  end
endmodule
